// ---- design/eta_consts.svh ----
// Purpose: Constants for the event trigger action engine
// Assumes: Included by bare name from every design file
// Notes: Definitions only
`ifndef ETA_CONSTS_SVH
`define ETA_CONSTS_SVH

// Table geometry
`define ETA_ROWS 32
`define ETA_ROW_W 5
`define ETA_CRIT 8
`define ETA_CODE_W 8
`define ETA_KIND_W 2
`define ETA_HIST 5
`define ETA_HIST_CNT_W 3

// Reset values
`define ETA_RST_ROWS 32'h0000_0000
`define ETA_RST_ROW 5'h00
`define ETA_RST_CODE 8'h00
`define ETA_RST_KIND 2'h0
`define ETA_RST_CNT 3'h0

`endif

// ---- design/eta_pkg.sv ----
// Purpose: Types for the event trigger action engine
// Assumes: eta_consts.svh provides the widths
// Notes: Nothing here is imported; users write eta_pkg::name
`include "eta_consts.svh"
package eta_pkg;

  // Action kinds carried with each row
  typedef enum logic [`ETA_KIND_W-1:0]
  {
    ETA_ACT_PRESET,
    ETA_ACT_HARD,
    ETA_ACT_ALERT,
    ETA_ACT_NONE
  } eta_kind_type;

  // Servicing state
  typedef enum logic
  {
    ETA_ST_IDLE,
    ETA_ST_SERVICE
  } eta_state_type;

endpackage : eta_pkg

// ---- design/eta_row_eval.sv ----
// Purpose: Combinational AND of the selected criteria for every row
// Assumes: Status inputs already in the engine clock domain
// Notes: A cleared care bit is a don't-care
`timescale 1ns/1ps
`include "eta_consts.svh"
module eta_row_eval (
  // Monitor status
  input wire logic [`ETA_CRIT-1:0] i_status,
  // Flattened row criteria
  input wire logic [`ETA_ROWS*`ETA_CRIT-1:0] i_care,
  input wire logic [`ETA_ROWS*`ETA_CRIT-1:0] i_value,
  // Per-row combined condition
  output logic [`ETA_ROWS-1:0] o_cond
);

  function automatic logic row_true(input logic [`ETA_CRIT-1:0] status,
                                    input logic [`ETA_CRIT-1:0] care,
                                    input logic [`ETA_CRIT-1:0] value);
    // Match on cared bits, don't-care bits forced true
    row_true = &((status ~^ value) | ~care);
  endfunction : row_true

  always_comb
  begin
    for (int r = 0; r < `ETA_ROWS; r++)
    begin
      o_cond[r] = row_true(i_status, i_care[r*`ETA_CRIT +: `ETA_CRIT],
                           i_value[r*`ETA_CRIT +: `ETA_CRIT]);
    end
  end

endmodule : eta_row_eval

// ---- design/eta_history.sv ----
// Purpose: Five-entry trigger history, newest first, with a readable snapshot
// Assumes: At most one push per cycle
// Notes: Snapshot changes only on refresh
`timescale 1ns/1ps
`include "eta_consts.svh"
module eta_history (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // New entry
  input wire logic i_push,
  input wire logic [`ETA_ROW_W-1:0] i_row,
  input wire logic [`ETA_KIND_W-1:0] i_kind,
  input wire logic [`ETA_CODE_W-1:0] i_code,
  // Refresh request
  input wire logic i_refresh,
  // Snapshot, entry 0 newest
  output logic [`ETA_HIST*`ETA_ROW_W-1:0] o_row,
  output logic [`ETA_HIST*`ETA_KIND_W-1:0] o_kind,
  output logic [`ETA_HIST*`ETA_CODE_W-1:0] o_code,
  output logic [`ETA_HIST_CNT_W-1:0] o_count
);

  logic [`ETA_HIST*`ETA_ROW_W-1:0] row_q, row_d;
  logic [`ETA_HIST*`ETA_KIND_W-1:0] kind_q, kind_d;
  logic [`ETA_HIST*`ETA_CODE_W-1:0] code_q, code_d;
  logic [`ETA_HIST_CNT_W-1:0] cnt_q, cnt_d;
  logic [`ETA_HIST*`ETA_ROW_W-1:0] snap_row_d;
  logic [`ETA_HIST*`ETA_KIND_W-1:0] snap_kind_d;
  logic [`ETA_HIST*`ETA_CODE_W-1:0] snap_code_d;
  logic [`ETA_HIST_CNT_W-1:0] snap_cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    row_d = row_q;
    kind_d = kind_q;
    code_d = code_q;
    cnt_d = cnt_q;
    if (i_push)
    begin
      // Oldest entry falls off the far end
      row_d = {row_q[(`ETA_HIST-1)*`ETA_ROW_W-1:0], i_row};
      kind_d = {kind_q[(`ETA_HIST-1)*`ETA_KIND_W-1:0], i_kind};
      code_d = {code_q[(`ETA_HIST-1)*`ETA_CODE_W-1:0], i_code};
      if (cnt_q != `ETA_HIST_CNT_W'(`ETA_HIST))
      begin
        cnt_d = cnt_q + 3'h1;
      end
    end
    snap_row_d = o_row;
    snap_kind_d = o_kind;
    snap_code_d = o_code;
    snap_cnt_d = o_count;
    if (i_refresh)
    begin
      // A push in the refresh cycle is included
      snap_row_d = row_d;
      snap_kind_d = kind_d;
      snap_code_d = code_d;
      snap_cnt_d = cnt_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      row_q <= '0;
      kind_q <= '0;
      code_q <= '0;
      cnt_q <= `ETA_RST_CNT;
      o_row <= '0;
      o_kind <= '0;
      o_code <= '0;
      o_count <= `ETA_RST_CNT;
    end
    else
    begin
      row_q <= row_d;
      kind_q <= kind_d;
      code_q <= code_d;
      cnt_q <= cnt_d;
      o_row <= snap_row_d;
      o_kind <= snap_kind_d;
      o_code <= snap_code_d;
      o_count <= snap_cnt_d;
    end
  end

endmodule : eta_history

// ---- design/eta_event_engine.sv ----
// Purpose: Prioritised event trigger engine with 32 rows and a trigger history
// Assumes: Status inputs come from logic on i_clock; row table is loaded
//          before the engine is enabled
// Notes: Row table is not cleared by reset so that a restored table survives
//
// Overview of operation
// - Master enable gates all evaluation and firing
// - Thirty-two rows, own criteria and action
// - Row 1 highest priority, row 32 lowest
// - Simultaneous triggers serviced lowest priority first
// - Row criteria combine as logical AND
// - Don't-care criteria excluded from the AND
// - Per-row engaged status flag
// - History of five newest triggers, newest first
// - Fire only on rising combined condition
// - Condition loss never disengages; next row does
// - Action is preset, hard-coded, alert or none
// - Row table retained; outside preset save/recall
`timescale 1ns/1ps
`include "eta_consts.svh"
module eta_event_engine (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Master enable and monitor status
  input wire logic i_enable,
  input wire logic [`ETA_CRIT-1:0] i_status,
  // Row table write
  input wire logic i_cfg_write,
  input wire logic [`ETA_ROW_W-1:0] i_cfg_row,
  input wire logic [`ETA_CRIT-1:0] i_cfg_care,
  input wire logic [`ETA_CRIT-1:0] i_cfg_value,
  input wire logic [`ETA_KIND_W-1:0] i_cfg_kind,
  input wire logic [`ETA_CODE_W-1:0] i_cfg_code,
  // Row table readback
  input wire logic [`ETA_ROW_W-1:0] i_cfg_read_row,
  output logic [`ETA_CRIT-1:0] o_cfg_care,
  output logic [`ETA_CRIT-1:0] o_cfg_value,
  output logic [`ETA_KIND_W-1:0] o_cfg_kind,
  output logic [`ETA_CODE_W-1:0] o_cfg_code,
  // History refresh
  input wire logic i_refresh,
  // Action issue
  output logic o_action_valid,
  output logic [`ETA_ROW_W-1:0] o_action_row,
  output logic [`ETA_KIND_W-1:0] o_action_kind,
  output logic [`ETA_CODE_W-1:0] o_action_code,
  output logic o_preset_recall,
  output logic o_hard_action,
  output logic o_alert,
  // Status
  output logic [`ETA_ROWS-1:0] o_engaged,
  output logic [`ETA_ROWS-1:0] o_cond,
  output logic o_busy,
  // History snapshot, entry 0 newest
  output logic [`ETA_HIST*`ETA_ROW_W-1:0] o_hist_row,
  output logic [`ETA_HIST*`ETA_KIND_W-1:0] o_hist_kind,
  output logic [`ETA_HIST*`ETA_CODE_W-1:0] o_hist_code,
  output logic [`ETA_HIST_CNT_W-1:0] o_hist_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Row table, kept apart from any preset store
  logic [`ETA_CRIT-1:0] care_mem [`ETA_ROWS];
  logic [`ETA_CRIT-1:0] value_mem [`ETA_ROWS];
  logic [`ETA_KIND_W-1:0] kind_mem [`ETA_ROWS];
  logic [`ETA_CODE_W-1:0] code_mem [`ETA_ROWS];
  logic [`ETA_ROWS*`ETA_CRIT-1:0] care_flat;
  logic [`ETA_ROWS*`ETA_CRIT-1:0] value_flat;
  logic [`ETA_ROWS-1:0] cond;

  // Servicing state
  eta_pkg::eta_state_type state_q, state_d;
  logic [`ETA_ROWS-1:0] prev_q, prev_d;
  logic [`ETA_ROWS-1:0] pending_q, pending_d;
  logic [`ETA_ROWS-1:0] rise;
  logic [`ETA_ROW_W-1:0] pick;
  logic fire;

  // Registered outputs
  logic act_valid_d;
  logic [`ETA_ROW_W-1:0] act_row_d;
  logic [`ETA_KIND_W-1:0] act_kind_d;
  logic [`ETA_CODE_W-1:0] act_code_d;
  logic preset_d, hard_d, alert_d;
  logic [`ETA_ROWS-1:0] engaged_d;
  logic [`ETA_CRIT-1:0] rd_care_d, rd_value_d;
  logic [`ETA_KIND_W-1:0] rd_kind_d;
  logic [`ETA_CODE_W-1:0] rd_code_d;

  // Lowest-priority pending row is the highest index set
  function automatic logic [`ETA_ROW_W-1:0] lowest_prio(input logic [`ETA_ROWS-1:0] v);
    lowest_prio = `ETA_RST_ROW;
    for (int i = 0; i < `ETA_ROWS; i++)
    begin
      if (v[i])
      begin
        lowest_prio = `ETA_ROW_W'(i);
      end
    end
  endfunction : lowest_prio

  ////////////////////////////////////////////////////////////////////////////
  // No reset here: the table is reloaded from non-volatile store, never
  // by a preset recall, and a device reset must not wipe it
  always_ff @(posedge i_clock)
  begin
    if (i_cfg_write)
    begin
      care_mem[i_cfg_row] <= i_cfg_care;
      value_mem[i_cfg_row] <= i_cfg_value;
      kind_mem[i_cfg_row] <= i_cfg_kind;
      code_mem[i_cfg_row] <= i_cfg_code;
    end
  end

  always_comb
  begin
    for (int r = 0; r < `ETA_ROWS; r++)
    begin
      care_flat[r*`ETA_CRIT +: `ETA_CRIT] = care_mem[r];
      value_flat[r*`ETA_CRIT +: `ETA_CRIT] = value_mem[r];
    end
  end

  eta_row_eval u_eval (
    .i_status(i_status),
    .i_care(care_flat),
    .i_value(value_flat),
    .o_cond(cond)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect, pending set and one service per cycle
  always_comb
  begin
    prev_d = prev_q;
    pending_d = pending_q;
    state_d = state_q;
    rise = '0;
    pick = lowest_prio(pending_q);
    fire = 1'b0;
    if (!i_enable)
    begin
      // Disabled: nothing evaluates, queued work is dropped
      prev_d = `ETA_RST_ROWS;
      pending_d = `ETA_RST_ROWS;
      state_d = eta_pkg::ETA_ST_IDLE;
    end
    else
    begin
      rise = cond & ~prev_q;
      prev_d = cond;
      if (state_q == eta_pkg::ETA_ST_SERVICE)
      begin
        fire = 1'b1;
        pending_d[pick] = 1'b0;
      end
      // A new edge wins over the service clear
      pending_d = pending_d | rise;
      case (state_q)
        eta_pkg::ETA_ST_IDLE:
        begin
          if (|rise)
          begin
            state_d = eta_pkg::ETA_ST_SERVICE;
          end
        end
        eta_pkg::ETA_ST_SERVICE:
        begin
          if (pending_d == `ETA_RST_ROWS)
          begin
            state_d = eta_pkg::ETA_ST_IDLE;
          end
        end
        default:
        begin
          state_d = eta_pkg::ETA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= eta_pkg::ETA_ST_IDLE;
      prev_q <= `ETA_RST_ROWS;
      pending_q <= `ETA_RST_ROWS;
    end
    else
    begin
      state_q <= state_d;
      prev_q <= prev_d;
      pending_q <= pending_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Action issue and engaged status
  always_comb
  begin
    act_valid_d = fire;
    act_row_d = o_action_row;
    act_kind_d = o_action_kind;
    act_code_d = o_action_code;
    preset_d = 1'b0;
    hard_d = 1'b0;
    alert_d = 1'b0;
    engaged_d = o_engaged;
    if (fire)
    begin
      act_row_d = pick;
      act_kind_d = kind_mem[pick];
      act_code_d = code_mem[pick];
      case (eta_pkg::eta_kind_type'(kind_mem[pick]))
        eta_pkg::ETA_ACT_PRESET: preset_d = 1'b1;
        eta_pkg::ETA_ACT_HARD: hard_d = 1'b1;
        eta_pkg::ETA_ACT_ALERT: alert_d = 1'b1;
        default: preset_d = 1'b0;
      endcase
      // Only a newly fired row moves the engaged flag
      engaged_d = `ETA_RST_ROWS;
      engaged_d[pick] = 1'b1;
    end
    rd_care_d = care_mem[i_cfg_read_row];
    rd_value_d = value_mem[i_cfg_read_row];
    rd_kind_d = kind_mem[i_cfg_read_row];
    rd_code_d = code_mem[i_cfg_read_row];
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_action_valid <= 1'b0;
      o_action_row <= `ETA_RST_ROW;
      o_action_kind <= `ETA_RST_KIND;
      o_action_code <= `ETA_RST_CODE;
      o_preset_recall <= 1'b0;
      o_hard_action <= 1'b0;
      o_alert <= 1'b0;
      o_engaged <= `ETA_RST_ROWS;
      o_cond <= `ETA_RST_ROWS;
      o_busy <= 1'b0;
      o_cfg_care <= '0;
      o_cfg_value <= '0;
      o_cfg_kind <= `ETA_RST_KIND;
      o_cfg_code <= `ETA_RST_CODE;
    end
    else
    begin
      o_action_valid <= act_valid_d;
      o_action_row <= act_row_d;
      o_action_kind <= act_kind_d;
      o_action_code <= act_code_d;
      o_preset_recall <= preset_d;
      o_hard_action <= hard_d;
      o_alert <= alert_d;
      o_engaged <= engaged_d;
      o_cond <= prev_d;
      o_busy <= (state_d == eta_pkg::ETA_ST_SERVICE);
      o_cfg_care <= rd_care_d;
      o_cfg_value <= rd_value_d;
      o_cfg_kind <= rd_kind_d;
      o_cfg_code <= rd_code_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // History logs in service order, so row 1 lands newest
  eta_history u_history (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_push(fire),
    .i_row(act_row_d),
    .i_kind(act_kind_d),
    .i_code(act_code_d),
    .i_refresh(i_refresh),
    .o_row(o_hist_row),
    .o_kind(o_hist_kind),
    .o_code(o_hist_code),
    .o_count(o_hist_count)
  );

endmodule : eta_event_engine

// ---- testbench/eta_checker.sv ----
// Purpose: Port assertions for the event trigger engine
// Assumes: One clock domain, async active-high reset
// Notes: Bound into every engine instance
`timescale 1ns/1ps
`include "eta_consts.svh"
module eta_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Inputs watched
  input wire logic i_enable,
  input wire logic i_refresh,
  // Outputs watched
  input wire logic o_action_valid,
  input wire logic [`ETA_ROW_W-1:0] o_action_row,
  input wire logic [`ETA_KIND_W-1:0] o_action_kind,
  input wire logic o_preset_recall,
  input wire logic o_hard_action,
  input wire logic o_alert,
  input wire logic [`ETA_ROWS-1:0] o_engaged,
  input wire logic [`ETA_ROWS-1:0] o_cond,
  input wire logic o_busy,
  input wire logic [`ETA_HIST*`ETA_ROW_W-1:0] o_hist_row,
  input wire logic [`ETA_HIST_CNT_W-1:0] o_hist_count
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////////
  a_off_silent: assert property (!i_enable |=> !o_action_valid && o_cond == '0)
    else $error("action or condition while disabled");
  a_queue_drains: assert property (o_busy && i_enable |=> o_action_valid)
    else $error("queued row not serviced");
  a_engaged_row: assert property (o_action_valid |-> o_engaged == (32'h1 << o_action_row))
    else $error("engaged flag not the serviced row");
  a_engaged_hold: assert property (!o_action_valid |-> $stable(o_engaged))
    else $error("engaged changed without action");
  a_engaged_single: assert property ($onehot0(o_engaged))
    else $error("several rows engaged");
  a_recall_kind: assert property
    (o_preset_recall == (o_action_valid && o_action_kind == eta_pkg::ETA_ACT_PRESET))
    else $error("preset strobe wrong");
  a_hard_kind: assert property
    (o_hard_action == (o_action_valid && o_action_kind == eta_pkg::ETA_ACT_HARD))
    else $error("hard action strobe wrong");
  a_alert_kind: assert property
    (o_alert == (o_action_valid && o_action_kind == eta_pkg::ETA_ACT_ALERT))
    else $error("alert strobe wrong");
  a_hist_depth: assert property (o_hist_count <= 3'h5)
    else $error("history deeper than five");
  // Rows too: the count alone stops moving once the history is full
  a_hist_frozen: assert property
    ($changed({o_hist_count, o_hist_row}) |-> $past(i_refresh))
    else $error("history changed without refresh");
endmodule : eta_checker

bind eta_event_engine eta_checker u_checker (.i_clock, .i_reset, .i_enable, .i_refresh,
  .o_action_valid, .o_action_row, .o_action_kind, .o_preset_recall, .o_hard_action,
  .o_alert, .o_engaged, .o_cond, .o_busy, .o_hist_row, .o_hist_count);

// ---- testbench/eta_action_sink.sv ----
// Purpose: Far-side action logic that records every issued action
// Assumes: Actions arrive as one-cycle valid pulses
// Notes: Log is read by the bench in service order
`timescale 1ns/1ps
`include "eta_consts.svh"
module eta_action_sink (
  // Clock
  input wire logic i_clock,
  // Action issue
  input wire logic i_valid,
  input wire logic [`ETA_ROW_W-1:0] i_row,
  input wire logic [`ETA_KIND_W-1:0] i_kind,
  input wire logic [`ETA_CODE_W-1:0] i_code
);
  logic [14:0] log_q [$];
  always @(posedge i_clock)
    if (i_valid === 1'b1)
      log_q.push_back({i_row, i_kind, i_code});
endmodule : eta_action_sink

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the event trigger engine
// Assumes: Inputs driven 10 ns after the rising edge
// Notes: Rows 0 and 3 use don't-care bits; other rows need bit 6
`timescale 1ns/1ps
`include "eta_consts.svh"
module testbench;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_enable = 1'b0;
  logic i_refresh = 1'b0;
  logic i_cfg_write = 1'b0;
  logic [7:0] i_status = 8'h00;
  logic [4:0] i_cfg_row = 5'h00, i_cfg_read_row = 5'h00;
  logic [7:0] i_cfg_care = 8'h00, i_cfg_value = 8'h00, i_cfg_code = 8'h00;
  logic [1:0] i_cfg_kind = 2'h0;
  logic [7:0] o_cfg_care, o_cfg_value, o_cfg_code, o_action_code;
  logic [1:0] o_cfg_kind, o_action_kind;
  logic [4:0] o_action_row;
  logic o_action_valid, o_preset_recall, o_hard_action, o_alert, o_busy;
  logic [31:0] o_engaged, o_cond;
  logic [24:0] o_hist_row;
  logic [9:0] o_hist_kind;
  logic [39:0] o_hist_code;
  logic [2:0] o_hist_count;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  eta_event_engine u_dut (.i_clock, .i_reset, .i_enable, .i_status, .i_cfg_write,
    .i_cfg_row, .i_cfg_care, .i_cfg_value, .i_cfg_kind, .i_cfg_code, .i_cfg_read_row,
    .o_cfg_care, .o_cfg_value, .o_cfg_kind, .o_cfg_code, .i_refresh, .o_action_valid,
    .o_action_row, .o_action_kind, .o_action_code, .o_preset_recall, .o_hard_action,
    .o_alert, .o_engaged, .o_cond, .o_busy, .o_hist_row, .o_hist_kind, .o_hist_code,
    .o_hist_count);
  eta_action_sink u_sink (.i_clock(i_clock), .i_valid(o_action_valid), .i_row(o_action_row),
    .i_kind(o_action_kind), .i_code(o_action_code));
  always #50 i_clock = ~i_clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #10;
  endtask : step
  task automatic refresh();
    i_refresh = 1'b1;
    step(1);
    i_refresh = 1'b0;
    step(1);
  endtask : refresh
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_table();
    i_cfg_write = 1'b1;
    for (int r = 0; r < 32; r++)
    begin
      i_cfg_row = 5'(r);
      i_cfg_care = (r == 0) ? 8'h80 : (r == 3) ? 8'h81 : 8'hff;
      i_cfg_value = (r == 0) ? 8'h80 : (r == 3) ? 8'h81 : 8'(8'h40 | r);
      i_cfg_kind = 2'(r);
      i_cfg_code = 8'(8'h10 + r);
      step(1);
    end
    i_cfg_write = 1'b0;
    // Reset must leave the table alone
    i_reset = 1'b1;
    step(1);
    i_reset = 1'b0;
    i_cfg_read_row = 5'h1f;
    step(2);
    // Row 31 as loaded above: care, value, kind, code
    check("cfg", {o_cfg_care, o_cfg_value, o_cfg_kind, o_cfg_code},
      {8'hff, 8'h5f, 2'h3, 8'h2f});
  endtask : t_table
  task automatic t_disable();
    i_status = 8'h81;
    step(4);
    check("quiet", {u_sink.log_q.size(), o_cond}, 64'h0);
  endtask : t_disable
  task automatic t_multi();
    i_enable = 1'b1;
    step(1);
    check("busy", o_busy, 1'b1);
    step(3);
    check("cond", o_cond, 32'h9);
    check("idle", o_busy, 1'b0);
    check("order",
      {u_sink.log_q.size(), u_sink.log_q[0][14:10], u_sink.log_q[1][14:10]},
      {32'd2, 5'd3, 5'd0});
    check("engaged", o_engaged, 32'h1);
    step(6);
    check("refire", u_sink.log_q.size(), 64'd2);
    i_status = 8'h80;
    step(4);
    check("and", o_cond, 32'h1);
    i_status = 8'h00;
    step(4);
    check("keep", {u_sink.log_q.size(), o_engaged}, {32'd2, 32'h1});
    refresh();
    check("hist2", {o_hist_count, o_hist_row[9:0]}, {3'h2, 5'd3, 5'd0});
  endtask : t_multi
  task automatic t_kinds();
    for (int r = 4; r < 12; r++)
    begin
      i_status = 8'(8'h40 | r);
      step(4);
      check("act", {o_action_row, o_action_kind, o_action_code},
        {5'(r), 2'(r), 8'(8'h10 + r)});
      i_status = 8'h00;
      step(1);
    end
    check("stale", o_hist_count, 3'h2);
    refresh();
    check("hist5", {o_hist_count, o_hist_row},
      {3'h5, 5'd7, 5'd8, 5'd9, 5'd10, 5'd11});
    check("kind0", o_hist_kind[1:0], 2'h3);
    check("codes", {o_hist_code[39:32], o_hist_code[7:0]}, {8'h17, 8'h1b});
  endtask : t_kinds
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard well above the expected 106 or so cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    step(5);
    i_reset = 1'b0;
    t_table();
    t_disable();
    t_multi();
    t_kinds();
    print_verdict();
  end
endmodule : testbench
